/* File: src/atc_pkg.sv */
`default_nettype none
package atc_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [5:0] IDX_STROBE = 6'h00;
    localparam logic [5:0] IDX_TRIG = 6'h10;
    localparam logic [5:0] IDX_DELAY = 6'h14;
    localparam logic [5:0] IDX_STATUS = 6'h18;
    localparam logic [5:0] IDX_COUNT = 6'h19;
    localparam logic [5:0] IDX_AICFG = 6'h20;
    localparam logic [2:0] TRIG_BYTES = 3'h2;
    localparam logic [2:0] DELAY_BYTES = 3'h4;
    localparam logic [2:0] AICFG_BYTES = 3'h2;

    // trigger configuration fields
    localparam int START_LSB = 0;
    localparam int STOP_LSB = 4;
    localparam int SYNC_LSB = 8;
    localparam int MODE_LSB = 12;
    localparam int EN_BIT = 15;
    localparam logic [15:0] TRIG_MASK = 16'hbfff;
    localparam logic [15:0] TRIG_RST = 16'h0000;

    // analog input general configuration fields
    localparam int SS_LSB = 0;
    localparam int GATE_BIT = 4;
    localparam int FC_SYNC_BIT = 5;
    localparam int FT_SYNC_BIT = 6;
    localparam int INV_BIT = 7;
    localparam int ENCB_LSB = 8;
    localparam int ENC_BIT = 10;
    localparam logic [15:0] AICFG_MASK = 16'h07ff;
    localparam logic [15:0] AICFG_RST = 16'h0000;

    localparam logic [31:0] DELAY_RST = 32'h0000_0000;

    // software strobe values
    localparam logic [7:0] SW_START = 8'h55;
    localparam logic [7:0] SW_STOP = 8'haa;
    localparam logic [7:0] SW_SYNC = 8'h5a;

    // delay timing: one step of the delay register versus one clock period
    localparam int CLK_MHZ = 25;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int STEP_NS = 25;

    typedef enum logic [1:0] {
        ATC_MODE_DIRECT = 2'b00,
        ATC_MODE_DELAY = 2'b01,
        ATC_MODE_SYNC_DELAY = 2'b10,
        ATC_MODE_RESERVED = 2'b11
    } atc_mode_e;

    typedef enum logic [2:0] {
        ATC_IDLE = 3'b000,
        ATC_ARMED = 3'b001,
        ATC_WAIT_SYNC = 3'b010,
        ATC_DELAY = 3'b011,
        ATC_RUN = 3'b100
    } atc_state_e;
endpackage
`default_nettype wire

/* File: src/atc_src_sel.sv */
`timescale 1ns/1ps
`default_nettype none
module atc_src_sel #(
    parameter bit DIN_OK = 1'b1
) (
    input wire logic [3:0] code_i, // source select code
    input wire logic sw_i, // software strobe event
    input wire logic aux_i, // event behind code 0010
    input wire logic timer_i, // sample/frame timer tick
    input wire logic [5:0] rise_i, // rising edges {digital_input_3..digital_input_0, c2, c0}
    input wire logic [5:0] fall_i, // falling edges, same order
    output logic hit_o // selected event fired
);
    logic [2:0] din_idx;

    assign din_idx = 3'h2 + {1'b0, code_i[2:1]};

    always_comb begin
        hit_o = 1'b0;
        if (code_i[3]) begin
            // input n rising is 1nn0, falling 1nn1
            hit_o = DIN_OK & (code_i[0] ? fall_i[din_idx] : rise_i[din_idx]);
        end else if (code_i[2]) begin
            hit_o = code_i[0] ? fall_i[{2'b00, code_i[1]}] : rise_i[{2'b00, code_i[1]}];
        end else begin
            unique case (code_i[1:0])
                2'b00: hit_o = 1'b0;
                2'b01: hit_o = sw_i;
                2'b10: hit_o = aux_i;
                2'b11: hit_o = timer_i;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: src/atc_top.sv */
// Behaviour
// - sources ignored unless enable set; resets off
// - mode selects direct, delayed, or sync-delayed start
// - strobe 0x5A gives sync event for code 0001
// - sync from counter 0/2 edges, codes 0100-0111
// - stop sources: strobe 0xAA, frame max, timer, counters, inputs 0-3
// - strobe 0x55 starts for code 0001; 0011 timer
// - start from counter 0/2 edges, codes 0100-0111
// - start from input 0-3 edges, codes 1000-1111
// - delay is register times 25 ns; resets zero
// - trigger config as two bytes or one word
// - analog input config bytes 0x20/0x21 or word
// - sampling gated by trigger only when gate set
// - frame timer sync clears timer on start
// - frame counter sync clears counter on start
// - encoding bit picks straight binary or two's complement
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module atc_top (
    input wire logic clk_i, // 25 MHz clock
    input wire logic rstn_i, // synchronous reset, active low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic counter0_output_i, // counter 0 output level
    input wire logic counter2_output_i, // counter 2 output level
    input wire logic [3:0] digital_input_i, // digital inputs 3..0
    input wire logic frame_timer_tick_i, // sample/frame timer pulse
    input wire logic frame_max_i, // frame maximum reached pulse
    input wire logic sample_request_i, // raw sample request
    input wire logic [15:0] adc_raw_i, // converter result, offset binary
    input wire logic adc_raw_valid_i, // result strobe
    output logic trigger_start_o, // trigger start pulse
    output logic trigger_stop_o, // trigger stop pulse
    output logic acquiring_o, // between start and stop
    output logic adc_sample_o, // gated sample request
    output logic frame_timer_clear_o, // clear sample/frame timer
    output logic frame_counter_clear_o, // clear frame counter
    output logic [15:0] adc_data_o, // formatted result
    output logic adc_data_valid_o, // formatted result strobe
    output logic [3:0] sample_source_select_o, // sampling source
    output logic filter_jumper_invert_o, // filter jumper invert
    output logic [1:0] input_encoding_behavior_o // encoding behaviour
);
    logic [15:0] trig_cfg;
    logic [31:0] delay_reg;
    logic [15:0] ai_cfg;
    logic [31:0] dly_cnt;
    logic [4:0] dly_acc;
    atc_pkg::atc_state_e state;
    logic ack;
    logic sw_start, sw_stop, sw_sync;
    logic [5:0] prev_in;
    logic edges_ok;
    logic [5:0] cur_in, rise, fall;
    logic start_hit, stop_hit, sync_hit;
    logic trigger_enable;
    atc_pkg::atc_mode_e start_mode;
    logic fire_start, fire_stop;
    logic bus_req, wr_fire;
    logic [5:0] idx;
    logic [31:0] rd_val;
    logic [5:0] step_sum;
    logic [1:0] step_cnt;
    logic [4:0] step_rem;

    function automatic logic atc_in_reg(input logic [5:0] i, input logic [5:0] base,
                                        input logic [2:0] nbytes);
        return (i >= base) && (i < base + {3'b000, nbytes});
    endfunction

    function automatic logic [31:0] atc_wr_merge(input logic [31:0] old, input logic [31:0] din,
                                                 input logic [3:0] sel, input logic [1:0] off);
        logic [31:0] res;
        int b;
        res = old;
        for (int k = 0; k < 4; k++) begin
            b = k + int'(off);
            if (sel[k] && b < 4) begin
                res[b*8 +: 8] = din[k*8 +: 8];
            end
        end
        return res;
    endfunction

    assign trigger_enable = trig_cfg[atc_pkg::EN_BIT];
    assign start_mode = atc_pkg::atc_mode_e'(trig_cfg[atc_pkg::MODE_LSB +: 2]);
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_fire = bus_req & wb_we_i & ack;
    assign idx = wb_adr_i[7:2];
    assign wb_ack_o = ack;

    // bus slave: answer one cycle after the request, for every address
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req & ~ack;
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        if (atc_in_reg(idx, atc_pkg::IDX_TRIG, atc_pkg::TRIG_BYTES)) begin
            rd_val = {16'h0000, trig_cfg} >> (8 * (idx - atc_pkg::IDX_TRIG));
        end else if (atc_in_reg(idx, atc_pkg::IDX_DELAY, atc_pkg::DELAY_BYTES)) begin
            rd_val = delay_reg >> (8 * (idx - atc_pkg::IDX_DELAY));
        end else if (atc_in_reg(idx, atc_pkg::IDX_AICFG, atc_pkg::AICFG_BYTES)) begin
            rd_val = {16'h0000, ai_cfg} >> (8 * (idx - atc_pkg::IDX_AICFG));
        end else if (idx == atc_pkg::IDX_STATUS) begin
            rd_val = {28'h0000000, acquiring_o, state};
        end else if (idx == atc_pkg::IDX_COUNT) begin
            rd_val = dly_cnt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req & ~ack & ~wb_we_i) begin
            wb_dat_o <= rd_val;
        end
    end

    // configuration registers; byte index selects which byte lane 0 lands in
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            trig_cfg <= atc_pkg::TRIG_RST;
        end else if (wr_fire && atc_in_reg(idx, atc_pkg::IDX_TRIG, atc_pkg::TRIG_BYTES)) begin
            trig_cfg <= 16'(atc_wr_merge({16'h0000, trig_cfg}, wb_dat_i, wb_sel_i,
                                         2'(idx - atc_pkg::IDX_TRIG))) & atc_pkg::TRIG_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            delay_reg <= atc_pkg::DELAY_RST;
        end else if (wr_fire && atc_in_reg(idx, atc_pkg::IDX_DELAY, atc_pkg::DELAY_BYTES)) begin
            delay_reg <= atc_wr_merge(delay_reg, wb_dat_i, wb_sel_i, 2'(idx - atc_pkg::IDX_DELAY));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ai_cfg <= atc_pkg::AICFG_RST;
        end else if (wr_fire && atc_in_reg(idx, atc_pkg::IDX_AICFG, atc_pkg::AICFG_BYTES)) begin
            ai_cfg <= 16'(atc_wr_merge({16'h0000, ai_cfg}, wb_dat_i, wb_sel_i,
                                       2'(idx - atc_pkg::IDX_AICFG))) & atc_pkg::AICFG_MASK;
        end
    end

    // strobe writes become one-cycle events; other values are ignored
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sw_start <= 1'b0;
            sw_stop <= 1'b0;
            sw_sync <= 1'b0;
        end else begin
            sw_start <= wr_fire && wb_sel_i[0] && idx == atc_pkg::IDX_STROBE
                        && wb_dat_i[7:0] == atc_pkg::SW_START;
            sw_stop <= wr_fire && wb_sel_i[0] && idx == atc_pkg::IDX_STROBE
                       && wb_dat_i[7:0] == atc_pkg::SW_STOP;
            sw_sync <= wr_fire && wb_sel_i[0] && idx == atc_pkg::IDX_STROBE
                       && wb_dat_i[7:0] == atc_pkg::SW_SYNC;
        end
    end

    // edge detection; the first cycle after reset is skipped so that a line
    // already high is not taken for a rising edge
    assign cur_in = {digital_input_i, counter2_output_i, counter0_output_i};
    assign rise = {6{edges_ok}} & cur_in & ~prev_in;
    assign fall = {6{edges_ok}} & ~cur_in & prev_in;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            prev_in <= 6'h00;
            edges_ok <= 1'b0;
        end else begin
            prev_in <= cur_in;
            edges_ok <= 1'b1;
        end
    end

    atc_src_sel #(.DIN_OK(1'b1)) u_start_sel (
        .code_i(trig_cfg[atc_pkg::START_LSB +: 4]),
        .sw_i(sw_start),
        .aux_i(1'b0),
        .timer_i(frame_timer_tick_i),
        .rise_i(rise),
        .fall_i(fall),
        .hit_o(start_hit)
    );

    atc_src_sel #(.DIN_OK(1'b1)) u_stop_sel (
        .code_i(trig_cfg[atc_pkg::STOP_LSB +: 4]),
        .sw_i(sw_stop),
        .aux_i(frame_max_i),
        .timer_i(frame_timer_tick_i),
        .rise_i(rise),
        .fall_i(fall),
        .hit_o(stop_hit)
    );

    // digital-input sync codes deliberately give no event
    atc_src_sel #(.DIN_OK(1'b0)) u_sync_sel (
        .code_i(trig_cfg[atc_pkg::SYNC_LSB +: 4]),
        .sw_i(sw_sync),
        .aux_i(1'b0),
        .timer_i(frame_timer_tick_i),
        .rise_i(rise),
        .fall_i(fall),
        .hit_o(sync_hit)
    );

    // a 40 ns clock covers 1.6 delay steps, so a remainder carries the
    // fraction and each cycle retires one or two steps
    always_comb begin
        step_sum = 6'(dly_acc) + 6'(atc_pkg::CLK_NS);
        step_cnt = 2'(step_sum / 6'(atc_pkg::STEP_NS));
        step_rem = 5'(step_sum - 6'(step_cnt) * 6'(atc_pkg::STEP_NS));
    end

    always_comb begin
        fire_start = 1'b0;
        if (trigger_enable && start_mode != atc_pkg::ATC_MODE_RESERVED) begin
            if (state == atc_pkg::ATC_ARMED && start_mode == atc_pkg::ATC_MODE_DIRECT) begin
                fire_start = start_hit;
            end else if (state == atc_pkg::ATC_DELAY) begin
                fire_start = dly_cnt == 32'h0000_0000;
            end
        end
    end

    assign fire_stop = trigger_enable && state == atc_pkg::ATC_RUN && stop_hit;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state <= atc_pkg::ATC_IDLE;
        end else if (!trigger_enable || start_mode == atc_pkg::ATC_MODE_RESERVED) begin
            state <= atc_pkg::ATC_IDLE;
        end else begin
            unique case (state)
                atc_pkg::ATC_IDLE: state <= atc_pkg::ATC_ARMED;
                atc_pkg::ATC_ARMED: begin
                    if (start_hit) begin
                        unique case (start_mode)
                            atc_pkg::ATC_MODE_DIRECT: state <= atc_pkg::ATC_RUN;
                            atc_pkg::ATC_MODE_DELAY: state <= atc_pkg::ATC_DELAY;
                            atc_pkg::ATC_MODE_SYNC_DELAY: state <= atc_pkg::ATC_WAIT_SYNC;
                            atc_pkg::ATC_MODE_RESERVED: state <= atc_pkg::ATC_IDLE;
                        endcase
                    end
                end
                atc_pkg::ATC_WAIT_SYNC: begin
                    if (sync_hit) begin
                        state <= atc_pkg::ATC_DELAY;
                    end
                end
                atc_pkg::ATC_DELAY: begin
                    if (fire_start) begin
                        state <= atc_pkg::ATC_RUN;
                    end
                end
                atc_pkg::ATC_RUN: begin
                    if (fire_stop) begin
                        state <= atc_pkg::ATC_ARMED;
                    end
                end
                default: state <= atc_pkg::ATC_IDLE;
            endcase
        end
    end

    // delay down-counter, loaded at the qualifying event
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            dly_cnt <= 32'h0000_0000;
            dly_acc <= 5'h00;
        end else if ((state == atc_pkg::ATC_ARMED && start_hit
                      && start_mode == atc_pkg::ATC_MODE_DELAY)
                     || (state == atc_pkg::ATC_WAIT_SYNC && sync_hit)) begin
            dly_cnt <= delay_reg;
            dly_acc <= 5'h00;
        end else if (state == atc_pkg::ATC_DELAY && dly_cnt != 32'h0000_0000) begin
            dly_cnt <= (dly_cnt <= 32'(step_cnt)) ? 32'h0000_0000 : dly_cnt - 32'(step_cnt);
            dly_acc <= step_rem;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            trigger_start_o <= 1'b0;
            trigger_stop_o <= 1'b0;
            frame_timer_clear_o <= 1'b0;
            frame_counter_clear_o <= 1'b0;
        end else begin
            trigger_start_o <= fire_start;
            trigger_stop_o <= fire_stop;
            frame_timer_clear_o <= fire_start & ai_cfg[atc_pkg::FT_SYNC_BIT];
            frame_counter_clear_o <= fire_start & ai_cfg[atc_pkg::FC_SYNC_BIT];
        end
    end

    assign acquiring_o = state == atc_pkg::ATC_RUN;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            adc_sample_o <= 1'b0;
        end else begin
            adc_sample_o <= sample_request_i & (~ai_cfg[atc_pkg::GATE_BIT] | acquiring_o);
        end
    end

    // converter delivers offset binary; flipping the sign bit gives two's complement
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            adc_data_o <= 16'h0000;
            adc_data_valid_o <= 1'b0;
        end else begin
            adc_data_valid_o <= adc_raw_valid_i;
            if (adc_raw_valid_i) begin
                adc_data_o <= {adc_raw_i[15] ^ ai_cfg[atc_pkg::ENC_BIT], adc_raw_i[14:0]};
            end
        end
    end

    assign sample_source_select_o = ai_cfg[atc_pkg::SS_LSB +: 4];
    assign filter_jumper_invert_o = ai_cfg[atc_pkg::INV_BIT];
    assign input_encoding_behavior_o = ai_cfg[atc_pkg::ENCB_LSB +: 2];

    a_disabled_no_start: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !$past(trigger_enable) |-> !trigger_start_o)
        else $error("start pulse while triggering disabled");

    a_direct_start: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state == atc_pkg::ATC_ARMED && trigger_enable && start_hit
         && start_mode == atc_pkg::ATC_MODE_DIRECT) |=> trigger_start_o && acquiring_o)
        else $error("direct mode did not start on the trigger");

    a_reserved_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
        start_mode == atc_pkg::ATC_MODE_RESERVED |=> !trigger_start_o && state == atc_pkg::ATC_IDLE)
        else $error("reserved mode produced activity");

    a_sw_strobe: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_fire && wb_sel_i[0] && idx == atc_pkg::IDX_STROBE && wb_dat_i[7:0] == atc_pkg::SW_START
         && state == atc_pkg::ATC_ARMED && trigger_enable && start_mode == atc_pkg::ATC_MODE_DIRECT
         && trig_cfg[atc_pkg::START_LSB +: 4] == 4'h1) |=> ##1 trigger_start_o)
        else $error("start strobe did not start the trigger");

    a_delay_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state == atc_pkg::ATC_ARMED && trigger_enable && start_hit
         && start_mode == atc_pkg::ATC_MODE_DELAY)
        |=> state == atc_pkg::ATC_DELAY && dly_cnt == $past(delay_reg))
        else $error("delay not loaded at trigger");

    a_delay_steps: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state == atc_pkg::ATC_DELAY && dly_cnt > 32'h0000_0002 && trigger_enable
         && start_mode != atc_pkg::ATC_MODE_RESERVED)
        |=> (dly_cnt == $past(dly_cnt) - 32'h0000_0001) || (dly_cnt == $past(dly_cnt) - 32'h0000_0002))
        else $error("delay counter stepped wrongly");

    a_gate_open: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!ai_cfg[atc_pkg::GATE_BIT] && sample_request_i) |=> adc_sample_o)
        else $error("ungated sample request dropped");

    a_gate_closed: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ai_cfg[atc_pkg::GATE_BIT] && !acquiring_o) |=> !adc_sample_o)
        else $error("sample passed a closed gate");

    a_timer_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        trigger_start_o |-> frame_timer_clear_o == $past(ai_cfg[atc_pkg::FT_SYNC_BIT]))
        else $error("frame timer clear wrong on start");

    a_twos_code: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (adc_raw_valid_i && adc_raw_i == 16'h0000 && ai_cfg[atc_pkg::ENC_BIT]) |=> adc_data_o == 16'h8000)
        else $error("two's complement zero scale wrong");

    a_ack_single: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0, rstn_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, c0 = 1'b0, c2 = 1'b0;
    logic ftk = 1'b0, fmax = 1'b0, sreq = 1'b0, rv = 1'b0, ft = 1'b0, fc = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, din = 4'h0, sss;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [15:0] raw = 16'h0, ad;
    logic ack, st, sp, acq, smp, ftc, fcc, adv, inv;
    logic [1:0] encb;
    int n_errors = 0, cmp_count = 0, n;

    always #20 clk_i = ~clk_i;

    atc_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .counter0_output_i(c0), .counter2_output_i(c2), .digital_input_i(din),
        .frame_timer_tick_i(ftk), .frame_max_i(fmax), .sample_request_i(sreq), .adc_raw_i(raw),
        .adc_raw_valid_i(rv), .trigger_start_o(st), .trigger_stop_o(sp), .acquiring_o(acq),
        .adc_sample_o(smp), .frame_timer_clear_o(ftc), .frame_counter_clear_o(fcc), .adc_data_o(ad),
        .adc_data_valid_o(adv), .sample_source_select_o(sss), .filter_jumper_invert_o(inv),
        .input_encoding_behavior_o(encb));

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // classic single cycle; the bus timeout ends the run
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d; sel <= s;
        for (i = 0; i < 16; i++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (i == 16) begin
            n_errors++;
            finish_test();
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        chk(q, e);
    endtask

    // clears must coincide with the start pulse
    task automatic start_in(input int hi);
        n = 0;
        while (st !== 1'b1 && n < hi) begin
            @(posedge clk_i);
            n++;
        end
        chk(st, 1'b1);
        if (st !== 1'b1) finish_test();
        chk({ftc, fcc}, {ft, fc});
    endtask

    task automatic no_start(input int k);
        repeat (k) begin
            @(posedge clk_i);
            chk(st, 1'b0);
        end
    endtask

    task automatic stop_in();
        n = 0;
        while (sp !== 1'b1 && n < 6) begin
            @(posedge clk_i);
            n++;
        end
        chk(sp, 1'b1);
        if (sp !== 1'b1) finish_test();
        repeat (2) @(posedge clk_i);
        chk(acq, 1'b0);
    endtask

    task automatic setin(input int code, input logic v);
        if (code < 8 && code[1])
            c2 <= v;
        else if (code < 8)
            c0 <= v;
        else
            din[(code - 8) / 2] <= v;
    endtask

    task automatic t_regs();
        rchk(8'h40, 32'h0);
        rchk(8'h50, 32'h0);
        rchk(8'h80, 32'h0);
        rchk(8'hfc, 32'h0);
        wb(1'b1, 8'h40, 32'hffff, 4'h3);
        wb(1'b1, 8'h44, 32'h12, 4'h1);
        rchk(8'h40, 32'h12ff);
        rchk(8'h44, 32'h12);
        wb(1'b1, 8'h80, 32'hffff, 4'h3);
        rchk(8'h80, 32'h07ff);
        chk({sss, inv, encb}, 7'h7f);
        wb(1'b1, 8'h50, 32'h11223344, 4'hf);
        wb(1'b1, 8'h5c, 32'haa, 4'h1);
        rchk(8'h50, 32'haa223344);
        wb(1'b1, 8'h50, 32'h0, 4'hf);
        wb(1'b1, 8'h40, 32'h0, 4'h3);
        $display("test regs done");
    endtask

    task automatic t_soft();
        wb(1'b1, 8'h80, 32'h60, 4'h3);
        ft = 1'b1; fc = 1'b1;
        wb(1'b1, 8'h40, 32'h0011, 4'h3);
        wb(1'b1, 8'h00, 32'h55, 4'h1);
        no_start(6);
        wb(1'b1, 8'h40, 32'h8011, 4'h3);
        wb(1'b1, 8'h00, 32'h55, 4'h1);
        start_in(4);
        @(posedge clk_i);
        chk(acq, 1'b1);
        wb(1'b1, 8'h00, 32'haa, 4'h1);
        stop_in();
        wb(1'b1, 8'h50, 32'h28, 4'hf);
        wb(1'b1, 8'h40, 32'h9011, 4'h3);
        wb(1'b1, 8'h00, 32'h55, 4'h1);
        start_in(34);
        chk(n >= 25 && n <= 30, 1'b1);
        wb(1'b1, 8'h40, 32'h0, 4'h3);
        wb(1'b1, 8'h50, 32'h0, 4'hf);
        wb(1'b1, 8'h40, 32'ha121, 4'h3);
        wb(1'b1, 8'h00, 32'h55, 4'h1);
        no_start(8);
        wb(1'b1, 8'h00, 32'h5a, 4'h1);
        start_in(6);
        @(posedge clk_i);
        fmax <= 1'b1;
        @(posedge clk_i);
        fmax <= 1'b0;
        stop_in();
        wb(1'b1, 8'h40, 32'hb011, 4'h3);
        wb(1'b1, 8'h00, 32'h55, 4'h1);
        no_start(8);
        $display("test soft done");
    endtask

    // every counter and input edge code, from the level opposite to the edge
    task automatic t_edges();
        wb(1'b1, 8'h80, 32'h0, 4'h3);
        ft = 1'b0; fc = 1'b0;
        for (int code = 4; code < 16; code++) begin
            wb(1'b1, 8'h40, 32'h0, 4'h3);
            setin(code, code[0]);
            wb(1'b1, 8'h40, 32'h8000 | code, 4'h3);
            repeat (2) @(posedge clk_i);
            setin(code, ~code[0]);
            start_in(5);
        end
        wb(1'b1, 8'h40, 32'h0, 4'h3);
        $display("test edges done");
    endtask

    // timer start in sync mode, counter 0 rise as sync, counter 2 fall as stop
    task automatic t_sync();
        wb(1'b1, 8'h40, 32'ha473, 4'h3);
        @(posedge clk_i);
        ftk <= 1'b1;
        @(posedge clk_i);
        ftk <= 1'b0;
        no_start(4);
        c0 <= 1'b1;
        start_in(5);
        @(posedge clk_i);
        c2 <= 1'b1;
        @(posedge clk_i);
        c2 <= 1'b0;
        stop_in();
        wb(1'b1, 8'h40, 32'h0, 4'h3);
        $display("test sync done");
    endtask

    task automatic t_data();
        wb(1'b1, 8'h80, 32'h10, 4'h3);
        sreq <= 1'b1;
        repeat (3) begin
            @(posedge clk_i);
            chk(smp, 1'b0);
        end
        wb(1'b1, 8'h80, 32'h0, 4'h3);
        repeat (2) @(posedge clk_i);
        chk(smp, 1'b1);
        sreq <= 1'b0;
        for (int e = 0; e < 2; e++) begin
            wb(1'b1, 8'h80, e ? 32'h400 : 32'h0, 4'h3);
            @(posedge clk_i);
            raw <= 16'h1234; rv <= 1'b1;
            @(posedge clk_i);
            rv <= 1'b0;
            @(posedge clk_i);
            chk({adv, ad}, {1'b1, e ? 16'h9234 : 16'h1234});
        end
        $display("test data done");
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_regs();
        t_soft();
        t_edges();
        t_sync();
        t_data();
        finish_test();
    end
endmodule
`default_nettype wire
